/* File: gli_board.sv */
// Purpose : Board side of the three pins: pull-ups and an optional external driver.
// Assumes : Every pin has a board pull-up, as an LED tied to the supply gives.
// Notes   : The wire level is resolved from the enables of both parties.
`timescale 1ns/1ps
module gli_board (
    input  wire logic [gli_pkg::NUM_PINS-1:0] gpio_o,    // Device drive levels.
    input  wire logic [gli_pkg::NUM_PINS-1:0] gpio_oe_n, // Device enables, low drives.
    input  wire logic [gli_pkg::NUM_PINS-1:0] ext_en,    // Board driver enables.
    input  wire logic [gli_pkg::NUM_PINS-1:0] ext_val,   // Board driver levels.
    output logic      [gli_pkg::NUM_PINS-1:0] pin_lvl    // Resolved wire levels.
);
    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // The device wins when it drives, then the board driver, then the pull-up.
    always_comb begin
        for (int i = 0; i < gli_pkg::NUM_PINS; i++) begin
            if (!gpio_oe_n[i]) begin
                pin_lvl[i] = gpio_o[i];  // Device drives the pin.
            end else if (ext_en[i]) begin
                pin_lvl[i] = ext_val[i]; // Board drives the pin.
            end else begin
                pin_lvl[i] = 1'h1;       // A released pin floats up to the pull-up.
            end
        end
    end
endmodule : gli_board

/* File: gli_pin.sv */
// Purpose : One multiplexed pin: input synchroniser and output driver selection.
// Assumes : The pin level arrives from outside the clock domain.
// Notes   : Outputs come from flip-flops; indicator use is always open-drain.
`timescale 1ns/1ps
module gli_pin (
    input  wire logic                  clk,      // Core clock.
    input  wire logic                  arst_n,   // Asynchronous reset, active low.
    input  wire gli_pkg::gli_pin_cfg_s cfg,      // Pin configuration.
    input  wire logic                  led_val,  // Indicator level for this pin.
    input  wire logic                  pin_i,    // Level seen on the pin.
    output logic                       pin_o,    // Level to drive on the pin.
    output logic                       pin_oe_n, // Output enable, low while driving.
    output logic                       pin_val   // Filtered input level.
);

    gli_pkg::gli_pin_st_s st_q;                  // Registered state.
    gli_pkg::gli_pin_st_s st_d;                  // Next state.

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Synchronises the input and picks the driver form for the pin.
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // The filtered level only moves once the last two stages agree.
        if (st_q.s2 == st_q.s3) begin
            st_d.val = st_q.s3;
        end
        if (cfg.led_sel) begin
            // Indicators only pull low and never drive high.
            st_d.o    = 1'h0;
            st_d.oe_n = led_val;
        end else begin
            // Each pin follows its own configured function.
            unique case (cfg.mode)
                gli_pkg::GLI_MODE_PUSHPULL: begin
                    st_d.o    = cfg.out_val;
                    st_d.oe_n = 1'h0;
                end
                gli_pkg::GLI_MODE_OPENDRAIN: begin
                    st_d.o    = 1'h0;
                    st_d.oe_n = cfg.out_val;
                end
                gli_pkg::GLI_MODE_INPUT: begin
                    st_d.o    = 1'h0;
                    st_d.oe_n = 1'h1;
                end
                default: begin
                    // An undefined mode code leaves the pin as an input.
                    st_d.o    = 1'h0;
                    st_d.oe_n = 1'h1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Registers the whole cell state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{s1: gli_pkg::SYNC_RST, s2: gli_pkg::SYNC_RST, s3: gli_pkg::SYNC_RST,
                      val: gli_pkg::SYNC_RST, o: 1'h0, oe_n: gli_pkg::OE_N_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_o    = st_q.o;
    assign pin_oe_n = st_q.oe_n;
    assign pin_val  = st_q.val;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_led_never_high: assert property (@(posedge clk) disable iff (!arst_n)
        cfg.led_sel |=> (pin_oe_n || !pin_o))
        else $error("Indicator pin driven high.");

    a_pushpull_drive: assert property (@(posedge clk) disable iff (!arst_n)
        (!cfg.led_sel && cfg.mode == gli_pkg::GLI_MODE_PUSHPULL) |=> (!pin_oe_n && pin_o == $past(cfg.out_val)))
        else $error("Push-pull pin not driving its value.");

    a_input_released: assert property (@(posedge clk) disable iff (!arst_n)
        (!cfg.led_sel && cfg.mode == gli_pkg::GLI_MODE_INPUT) |=> pin_oe_n)
        else $error("Input pin is driven.");

endmodule : gli_pin

/* File: gli_pkg.sv */
// Purpose : Shared constants and types for the three-pin GPIO and LED indicator block.
// Assumes : A 10 MHz core clock; link status inputs come from logic on the same clock.
// Notes   : Every width and timing count and all non-zero reset values of the block live here.
package gli_pkg;

    // ------------------------------------------------------------------
    // Sizes and pin roles
    // ------------------------------------------------------------------
    localparam int NUM_PINS  = 3;        // Number of multiplexed pins.
    localparam int PIN_SPEED = 0;        // Pin that carries the speed indicator.
    localparam int PIN_LINK  = 1;        // Pin that carries the link/activity indicator.
    localparam int PIN_DUPLX = 2;        // Pin that carries the duplex indicator.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ     = 10000000;                 // Core clock rate in hertz.
    localparam int ACT_MS     = 80;                       // Activity off and on interval in ms.
    localparam int ACT_CYCLES = ACT_MS * (CLK_HZ / 1000); // Interval as clock cycles.
    localparam int CNT_W      = 20;                       // Width of the interval counter.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic IND_RST   = 1'h1;   // Indicators start dark (released high).
    localparam logic OE_N_RST  = 1'h1;   // Pins start undriven.
    localparam logic SYNC_RST  = 1'h1;   // Synchroniser stages start at the pulled-up level.

    // Pin function chosen by configuration.
    typedef enum logic [1:0] {
        GLI_MODE_INPUT,                  // Pin is an input only.
        GLI_MODE_PUSHPULL,               // Pin drives both levels.
        GLI_MODE_OPENDRAIN               // Pin drives low, releases for high.
    } gli_mode_e;

    // Link/activity indicator sequence.
    typedef enum logic [1:0] {
        GLI_ACT_IDLE,                    // Link up, indicator lit steady.
        GLI_ACT_OFF,                     // Indicator dark for one interval.
        GLI_ACT_HOLD                     // Indicator lit for at least one interval.
    } gli_act_e;

    // Configuration of one pin.
    typedef struct packed {
        gli_mode_e mode;                 // Pin function when not an indicator.
        logic      out_val;              // Level to drive in output modes.
        logic      led_sel;              // Pin carries its status indicator.
    } gli_pin_cfg_s;

    // Link state from the PHY.
    typedef struct packed {
        logic link_up;                   // A valid link exists.
        logic speed_100;                 // Link runs at 100 Mb.
        logic full_duplex;               // Link runs full duplex.
        logic an_busy;                   // Auto-negotiation in progress.
        logic activity;                  // One-cycle pulse per TX or RX activity.
    } gli_link_s;

    // State of one pin cell.
    typedef struct packed {
        logic s1;                        // First synchroniser stage.
        logic s2;                        // Second synchroniser stage.
        logic s3;                        // Third synchroniser stage.
        logic val;                       // Filtered input level.
        logic o;                         // Driven output level.
        logic oe_n;                      // Output enable, low while driving.
    } gli_pin_st_s;

    // State of the indicator logic.
    typedef struct packed {
        gli_act_e         act;           // Link/activity sequence state.
        logic [CNT_W-1:0] cnt;           // Interval counter.
        logic             pend;          // Activity seen since the last off pulse began.
        logic             spd_n;         // Speed indicator, low at 100 Mb.
        logic             lnk_n;         // Link/activity indicator, low when lit.
        logic             dup_n;         // Duplex indicator, low at full duplex.
    } gli_st_s;

endpackage : gli_pkg

/* File: gli_top.sv */
// Purpose : Three general-purpose pins that can also show link speed, link/activity and duplex.
// Assumes : Link status inputs are on the core clock; activity is a one-cycle pulse.
// Notes   : Configuration arrives as plain inputs; there is no register bus.
//
// Contract
// - Each pin configurable as input, push-pull, open-drain.
// - Indicator pins are open-drain, never driven high.
// - Speed indicator low at 100 Mb.
// - Speed indicator high in negotiation, unplugged, 10 Mb.
// - Link indicator lit while link up, no pulse.
// - Activity turns link indicator off for 80 ms.
// - Then lit at least 80 ms; repeat on activity.
// - Duplex indicator low at full duplex.
`timescale 1ns/1ps
module gli_top #(
    parameter int unsigned ACT_CYCLES = gli_pkg::ACT_CYCLES     // Off and on interval in cycles.
) (
    input  wire logic                                         clk,                       // Core clock.
    input  wire logic                                         arst_n,                    // Reset, active low.
    input  wire gli_pkg::gli_link_s                           link,                      // Link state.
    input  wire gli_pkg::gli_pin_cfg_s [gli_pkg::NUM_PINS-1:0] pin_cfg,                  // Per-pin configuration.
    input  wire logic [gli_pkg::NUM_PINS-1:0]                 gpio_i,                    // Pin levels.
    output logic      [gli_pkg::NUM_PINS-1:0]                 gpio_o,                    // Pin drive levels.
    output logic      [gli_pkg::NUM_PINS-1:0]                 gpio_oe_n,                 // Pin enables, low drives.
    output logic      [gli_pkg::NUM_PINS-1:0]                 gpio_val,                  // Filtered pin inputs.
    output logic                                              speed_indicator_n,         // Speed indicator.
    output logic                                              link_activity_indicator_n, // Link/activity indicator.
    output logic                                              duplex_indicator_n         // Duplex indicator.
);

    localparam logic [gli_pkg::CNT_W-1:0] LAST = gli_pkg::CNT_W'(ACT_CYCLES - 1); // Final count.

    gli_pkg::gli_st_s                  st_q;   // Registered state.
    gli_pkg::gli_st_s                  st_d;   // Next state.
    logic [gli_pkg::NUM_PINS-1:0]      led_v;  // Indicator level per pin.

    // ------------------------------------------------------------------
    // Indicator logic
    // ------------------------------------------------------------------
    // Derives the three indicators from the link state.
    always_comb begin
        st_d       = st_q;
        // Lit only at 100 Mb with a settled link; dark otherwise.
        st_d.spd_n = !(link.link_up && link.speed_100 && !link.an_busy);
        // Lit only at full duplex; released at half duplex or no link.
        st_d.dup_n = !(link.link_up && link.full_duplex);
        if (!link.link_up) begin
            // No link: dark and the sequence restarts.
            st_d.act   = gli_pkg::GLI_ACT_IDLE;
            st_d.cnt   = '0;
            st_d.pend  = 1'h0;
            st_d.lnk_n = 1'h1;
        end else begin
            unique case (st_q.act)
                gli_pkg::GLI_ACT_IDLE: begin
                    // Steady lit while nothing happens.
                    st_d.lnk_n = 1'h0;
                    if (link.activity) begin
                        // Activity starts an off pulse.
                        st_d.act   = gli_pkg::GLI_ACT_OFF;
                        st_d.cnt   = '0;
                        st_d.lnk_n = 1'h1;
                    end
                end
                gli_pkg::GLI_ACT_OFF: begin
                    // Activity during the pulse is remembered for the next one.
                    if (link.activity) begin
                        st_d.pend = 1'h1;
                    end
                    if (st_q.cnt == LAST) begin
                        // Off pulse over; a lit interval follows.
                        st_d.act   = gli_pkg::GLI_ACT_HOLD;
                        st_d.cnt   = '0;
                        st_d.lnk_n = 1'h0;
                    end else begin
                        st_d.cnt   = st_q.cnt + 1'h1;
                        st_d.lnk_n = 1'h1;
                    end
                end
                gli_pkg::GLI_ACT_HOLD: begin
                    st_d.lnk_n = 1'h0;
                    if (link.activity) begin
                        st_d.pend = 1'h1;
                    end
                    if (st_q.cnt == LAST) begin
                        st_d.cnt = '0;
                        if (st_q.pend || link.activity) begin
                            // Continued activity repeats the off pulse.
                            st_d.act   = gli_pkg::GLI_ACT_OFF;
                            st_d.pend  = 1'h0;
                            st_d.lnk_n = 1'h1;
                        end else begin
                            st_d.act = gli_pkg::GLI_ACT_IDLE;
                        end
                    end else begin
                        // Minimum lit time not yet reached.
                        st_d.cnt = st_q.cnt + 1'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Registers the indicator state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{act: gli_pkg::GLI_ACT_IDLE, cnt: '0, pend: 1'h0,
                      spd_n: gli_pkg::IND_RST, lnk_n: gli_pkg::IND_RST, dup_n: gli_pkg::IND_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign speed_indicator_n         = st_q.spd_n;
    assign link_activity_indicator_n = st_q.lnk_n;
    assign duplex_indicator_n        = st_q.dup_n;

    // Routes each indicator to its own pin.
    always_comb begin
        led_v                     = '1;
        led_v[gli_pkg::PIN_SPEED] = st_q.spd_n;
        led_v[gli_pkg::PIN_LINK]  = st_q.lnk_n;
        led_v[gli_pkg::PIN_DUPLX] = st_q.dup_n;
    end

    // ------------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------------
    // One cell per pin handles sync and drive form.
    for (genvar i = 0; i < gli_pkg::NUM_PINS; i++) begin : g_pin
        gli_pin u_pin (
            .clk      (clk),
            .arst_n   (arst_n),
            .cfg      (pin_cfg[i]),
            .led_val  (led_v[i]),
            .pin_i    (gpio_i[i]),
            .pin_o    (gpio_o[i]),
            .pin_oe_n (gpio_oe_n[i]),
            .pin_val  (gpio_val[i])
        );
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Start of an off pulse from the lit state.
    sequence s_pulse_start;
        st_q.act == gli_pkg::GLI_ACT_IDLE && link.link_up && link.activity;
    endsequence

    a_speed_lit: assert property (@(posedge clk) disable iff (!arst_n)
        (link.link_up && link.speed_100 && !link.an_busy) |=> !speed_indicator_n)
        else $error("Speed indicator not low at 100 Mb.");

    a_speed_dark: assert property (@(posedge clk) disable iff (!arst_n)
        (!link.link_up || !link.speed_100 || link.an_busy) |=> speed_indicator_n)
        else $error("Speed indicator not high.");

    a_duplex_lit: assert property (@(posedge clk) disable iff (!arst_n)
        (link.link_up && link.full_duplex) |=> !duplex_indicator_n)
        else $error("Duplex indicator not low at full duplex.");

    a_no_link_dark: assert property (@(posedge clk) disable iff (!arst_n)
        !link.link_up |=> (link_activity_indicator_n && duplex_indicator_n))
        else $error("Indicator lit without link.");

    a_link_steady: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.act == gli_pkg::GLI_ACT_IDLE && link.link_up && !link.activity) |=> !link_activity_indicator_n)
        else $error("Link indicator not lit on idle link.");

    a_pulse_starts: assert property (@(posedge clk) disable iff (!arst_n)
        s_pulse_start |=> (link_activity_indicator_n && st_q.act == gli_pkg::GLI_ACT_OFF && st_q.cnt == '0))
        else $error("Activity did not start an off pulse.");

    a_off_holds: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.act == gli_pkg::GLI_ACT_OFF && st_q.cnt != LAST && link.link_up)
        |=> (st_q.act == gli_pkg::GLI_ACT_OFF && link_activity_indicator_n && st_q.cnt == $past(st_q.cnt) + 1'h1))
        else $error("Off pulse ended early.");

    a_hold_min_lit: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.act == gli_pkg::GLI_ACT_HOLD && st_q.cnt != LAST && link.link_up)
        |=> (st_q.act == gli_pkg::GLI_ACT_HOLD && !link_activity_indicator_n))
        else $error("Lit interval cut short.");

    a_repeat_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.act == gli_pkg::GLI_ACT_HOLD && st_q.cnt == LAST && st_q.pend && link.link_up)
        |=> (st_q.act == gli_pkg::GLI_ACT_OFF && link_activity_indicator_n))
        else $error("Pending activity did not repeat the pulse.");

    // Last cycle of an off pulse on a live link.
    sequence s_off_last;
        st_q.act == gli_pkg::GLI_ACT_OFF && st_q.cnt == LAST && link.link_up;
    endsequence

    // Last cycle of a lit interval with no activity owed.
    sequence s_hold_quiet_end;
        st_q.act == gli_pkg::GLI_ACT_HOLD && st_q.cnt == LAST && !st_q.pend && !link.activity
            && link.link_up;
    endsequence

    // An off pulse on a live link hands over to a full lit interval from count zero.
    a_off_to_hold: assert property (@(posedge clk) disable iff (!arst_n)
        s_off_last |=> (st_q.act == gli_pkg::GLI_ACT_HOLD && st_q.cnt == '0 && !link_activity_indicator_n))
        else $error("Off pulse did not end in a lit interval.");

    // With nothing owed, the lit interval settles into the steady lit state.
    a_hold_to_idle: assert property (@(posedge clk) disable iff (!arst_n)
        s_hold_quiet_end |=> (st_q.act == gli_pkg::GLI_ACT_IDLE && !link_activity_indicator_n))
        else $error("Quiet lit interval did not settle.");

    // Activity during an off pulse is kept for the next repeat.
    a_act_kept: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q.act == gli_pkg::GLI_ACT_OFF && link.link_up && link.activity) |=> st_q.pend)
        else $error("Activity during an off pulse was lost.");

    // Half duplex or no link leaves the duplex indicator released.
    a_duplex_dark: assert property (@(posedge clk) disable iff (!arst_n)
        (!link.link_up || !link.full_duplex) |=> duplex_indicator_n)
        else $error("Duplex indicator lit at half duplex.");

endmodule : gli_top

/* File: tb_top.sv */
// Purpose : Self-checking bench for the GPIO and LED indicator block.
// Assumes : A shortened activity interval of eight cycles.
// Notes   : Inputs change by non-blocking assignment on the rising edge.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    localparam int ACT_N = 8;                                   // Shortened interval in cycles.
    logic                                        clk;           // Core clock.
    logic                                        arst_n;        // Reset, active low.
    gli_pkg::gli_link_s                          link;          // Link state stimulus.
    gli_pkg::gli_pin_cfg_s [gli_pkg::NUM_PINS-1:0] pin_cfg;     // Pin configuration.
    logic [gli_pkg::NUM_PINS-1:0]                gpio_i;        // Resolved pin levels.
    logic [gli_pkg::NUM_PINS-1:0]                gpio_o;        // Device drive levels.
    logic [gli_pkg::NUM_PINS-1:0]                gpio_oe_n;     // Device enables.
    logic [gli_pkg::NUM_PINS-1:0]                gpio_val;      // Filtered inputs.
    logic [gli_pkg::NUM_PINS-1:0]                ext_en;        // Board driver enables.
    logic [gli_pkg::NUM_PINS-1:0]                ext_val;       // Board driver levels.
    logic                                        spd_n;         // Speed indicator.
    logic                                        lnk_n;         // Link/activity indicator.
    logic                                        dup_n;         // Duplex indicator.
    int                                          fail_count;    // Mismatches seen.
    int                                          n_tests;       // Comparisons made.

    // Clock at 10 MHz.
    always #50 clk = ~clk;

    gli_top #(.ACT_CYCLES(ACT_N)) u_gli_top (
        .clk(clk), .arst_n(arst_n), .link(link), .pin_cfg(pin_cfg), .gpio_i(gpio_i),
        .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .gpio_val(gpio_val), .speed_indicator_n(spd_n),
        .link_activity_indicator_n(lnk_n), .duplex_indicator_n(dup_n)
    );
    gli_board u_gli_board (
        .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(gpio_i)
    );

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // Checks the values held during reset, then releases it.
    task automatic t_reset();
        repeat (20) @(posedge clk);
        #1;
        `CHK({spd_n, lnk_n, dup_n, gpio_oe_n, gpio_o, gpio_val}, 12'hFC7)
        @(posedge clk) arst_n <= 1'h1;
        $display("t_reset done");
    endtask : t_reset

    // Walks every link state combination with activity held low through both level indicators.
    task automatic t_speed();
        for (int v = 0; v < 16; v++) begin
            @(posedge clk) link <= gli_pkg::gli_link_s'({v[3:0], 1'h0});
            @(posedge clk);
            #1;
            `CHK(spd_n, ~(v[3] & v[2] & ~v[0]))
            `CHK(dup_n, ~(v[3] & v[1]))
            if (!v[3]) begin
                `CHK(lnk_n, 1'h1)
            end else begin
                `CHK(lnk_n, 1'h0)
            end
        end
        $display("t_speed done");
    endtask : t_speed

    // One activity pulse, activity in the off pulse and the lit hold merged into one repeat, then link loss.
    task automatic t_activity();
        @(posedge clk) link <= '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
        repeat (3) @(posedge clk);
        #1;
        `CHK(lnk_n, 1'h0)
        @(posedge clk) link.activity <= 1'h1;
        @(posedge clk) link.activity <= 1'h0;
        for (int i = 1; i <= 5 * ACT_N; i++) begin
            @(posedge clk) link.activity <= (i == 2) || (i == ACT_N + 2);
            #1;
            `CHK(lnk_n, (i < ACT_N) || (i >= 2 * ACT_N && i < 3 * ACT_N))
        end
        @(posedge clk) link.link_up <= 1'h0;
        @(posedge clk);
        #1;
        `CHK(lnk_n, 1'h1)
        `CHK(dup_n, 1'h1)
        $display("t_activity done");
    endtask : t_activity

    // Every mode on every pin, staggered so that neighbours differ.
    task automatic t_pins();
        int mp;
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                @(posedge clk) begin
                    for (int p = 0; p < 3; p++) begin
                        mp = (m + p) % 4;
                        pin_cfg[p] <= '{gli_pkg::gli_mode_e'(mp[1:0]), v[0], 1'h0};
                        ext_en[p] <= (mp == 0) || (mp == 3);
                    end
                    ext_val <= {3{~v[0]}};
                end
                repeat (6) @(posedge clk);
                #1;
                for (int p = 0; p < 3; p++) begin
                    mp = (m + p) % 4;
                    if (mp == 1) begin
                        `CHK({gpio_oe_n[p], gpio_o[p]}, {1'h0, v[0]})
                    end else if (mp == 2) begin
                        `CHK({gpio_oe_n[p], gpio_o[p]}, {v[0], 1'h0})
                    end else begin
                        `CHK(gpio_oe_n[p], 1'h1)
                    end
                    `CHK(gpio_val[p], (mp == 0 || mp == 3) ? ~v[0] : v[0])
                end
            end
        end
        $display("t_pins done");
    endtask : t_pins

    // Indicator pins asked to drive high in push-pull stay open-drain.
    task automatic t_led();
        @(posedge clk) begin
            pin_cfg <= {3{gli_pkg::gli_pin_cfg_s'{gli_pkg::GLI_MODE_PUSHPULL, 1'h1, 1'h1}}};
            ext_en <= 3'h0;
            link <= '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
        end
        repeat (3) @(posedge clk);
        #1;
        `CHK({gpio_oe_n, gpio_o}, 6'h00)
        @(posedge clk) link.link_up <= 1'h0;
        repeat (6) @(posedge clk);
        #1;
        `CHK({gpio_oe_n, gpio_o, gpio_val}, 9'h1C7)
        $display("t_led done");
    endtask : t_led

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    // Drives every input at time zero, then runs the scenarios in turn.
    initial begin
        clk = 1'h0;
        arst_n = 1'h0;
        link = '0;
        pin_cfg = '0;
        ext_en = 3'h0;
        ext_val = 3'h0;
        fail_count = 0;
        n_tests = 0;
        t_reset();
        t_speed();
        t_activity();
        t_pins();
        t_led();
        final_report();
    end

    // Cuts a hang short well beyond the fewer than two hundred cycles the scenarios need.
    initial begin
        #(5000 * 100);
        fail_count++;
        final_report();
    end
endmodule : tb_top
